// file: sim/serial_peer.sv
// Far-side model: an asynchronous serial transmitter and a mode-0 slave.
// Assumes the bench calls its tasks just after a rising edge of mclk_i.
`timescale 1ns/10ps
module serial_peer (
	// Clock.
	input wire logic mclk_i,
	// Serial pins as seen from the far side.
	input wire logic line_i,
	input wire logic sclk_i,
	output logic line_o
);
	logic [7:0] miso_q;
	logic [7:0] mosi_q;
	int edges;

	// The line idles high before the first frame.
	initial begin
		line_o = 1'b1;
		miso_q = 8'h00;
		mosi_q = 8'h00;
		edges = 0;
	end

	// Sends start, eight data bits LSB first and a stop bit of the given level.
	task automatic send(input logic [7:0] b, input int per, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_o <= f[i];
			repeat (per) @(posedge mclk_i);
		end
		line_o <= 1'b1;
	endtask

	// Pulls the line low for a few cycles only, like a noise spike.
	task automatic glitch(input int n);
		line_o <= 1'b0;
		repeat (n) @(posedge mclk_i);
		line_o <= 1'b1;
	endtask

	// Prepares the byte returned in the next transfer, first bit on the line at once.
	task automatic load(input logic [7:0] b);
		miso_q <= b;
		line_o <= b[7];
		edges <= 0;
	endtask

	// Captures the master-out bit on each rising transfer clock edge.
	always @(posedge sclk_i) begin
		mosi_q <= {mosi_q[6:0], line_i};
		edges <= edges + 1;
	end

	// Shifts the next bit out on the falling edge; after a byte the line is not held.
	always @(negedge sclk_i) begin
		if (edges > 0 && edges % 8 == 0) begin
			line_o <= ~line_o;
		end else if (edges > 0) begin
			line_o <= miso_q[6];
			miso_q <= {miso_q[6:0], 1'b0};
		end
	end
endmodule

// file: sim/test_usart_baud_sampling_spi_master.sv
// Self-checking bench for the serial port core: registers, baud timing, receive
// sampling and master transfers. Assumes the far-side model serial_peer.
`timescale 1ns/10ps
module test_usart_baud_sampling_spi_master
	import usart_pkg::*;
;
	logic mclk_i;
	logic rst_i;
	logic ce_i;
	logic [2:0] hsize_i;
	logic hwrite_i;
	logic [1:0] htrans_i;
	logic [31:0] haddr_i;
	logic [31:0] hwdata_i;
	logic [31:0] hrdata_o;
	logic hreadyout_o;
	logic hresp_o;
	logic rxd_i;
	logic txd_o;
	logic txd_oe_o;
	logic sck_o;
	logic sck_oe_o;
	logic [31:0] rd;
	int fails;
	int num_checks;
	int n;
	// Frame low time of start plus eight zero bits is nine tenths of a frame.
	logic [11:0] dv [5] = '{12'h000, 12'h001, 12'h001, 12'h000, 12'h001};
	logic [3:0] ex [5] = '{4'h0, 4'h0, 4'hF, 4'h0, 4'h1};
	logic ds [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	int cyc [5] = '{144, 288, 216, 72, 576};

	usart_core u_dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .hsel_i(1'b1),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
		.hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .rxd_i(rxd_i), .txd_o(txd_o),
		.txd_oe_o(txd_oe_o), .transfer_clock_pin_o(sck_o),
		.transfer_clock_pin_oe_o(sck_oe_o)
	);

	serial_peer u_peer (.mclk_i(mclk_i), .line_i(txd_o), .sclk_i(sck_o), .line_o(rxd_i));

	// Free-running 125 MHz clock.
	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end

	// Waits for hready sampled high at a rising edge; read data is taken at that edge.
	task automatic wait_rdy(output logic [31:0] d);
		int k;
		k = 0;
		do begin
			@(posedge mclk_i);
			k++;
		end while (hreadyout_o !== 1'b1 && k < 50);
		d = hrdata_o;
		if (hreadyout_o !== 1'b1) begin
			fails++;
			final_report();
		end
	endtask

	// One single word transfer: address phase, then data phase.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		htrans_i <= 2'b10;
		haddr_i <= {24'h0, a};
		hwrite_i <= wr;
		hsize_i <= 3'b010;
		wait_rdy(rd);
		htrans_i <= 2'b00;
		hwdata_i <= wd;
		wait_rdy(rd);
	endtask

	// Compares a value with its expectation and counts the outcome.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Reads a register and compares the masked bits.
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask

	// Counts the cycles of the next low run on the transmit line.
	task automatic low_run(output int c);
		c = 0;
		while (txd_o !== 1'b0) @(negedge mclk_i);
		while (txd_o === 1'b0) begin
			@(negedge mclk_i);
			c++;
		end
		@(posedge mclk_i);
	endtask

	// Prints the end of one test.
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Cuts a hang short well after the tests should have ended.
	initial begin
		repeat (40000) @(posedge mclk_i);
		fails++;
		final_report();
	end

	// Main sequence of tests.
	initial begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		hsize_i = 3'b010;
		htrans_i = 2'b00;
		haddr_i = 32'h0;
		hwrite_i = 1'b0;
		hwdata_i = 32'h0;
		fails = 0;
		num_checks = 0;
		repeat (6) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		rchk(CTRL_OFS, 32'hFFFFFFFF, 32'h00000000);
		rchk(BAUD_OFS, 32'hFFFFFFFF, 32'h00000000);
		rchk(DATA_OFS, 32'hFFFFFFFF, 32'h00000000);
		rchk(STAT_OFS, 32'hFFFFFFFF, 32'h00000020);
		rchk(8'h10, 32'hFFFFFFFF, 32'h00000000);
		// A write while the clock enable is low must leave no trace.
		ce_i <= 1'b0;
		bus(1'b1, CTRL_OFS, 32'h4);
		ce_i <= 1'b1;
		rchk(CTRL_OFS, 32'hFFFFFFFF, 32'h00000000);
		done("reset");
		// Exponent minus one with divider one averages one and a half cycles per tick.
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, CTRL_OFS, {29'h0, ds[i], 2'b01});
			bus(1'b1, BAUD_OFS, {16'h0, ex[i], dv[i]});
			// The second byte loads on a tick, so its low run spans whole tick periods.
			bus(1'b1, DATA_OFS, 32'h0);
			bus(1'b1, DATA_OFS, 32'h0);
			low_run(n);
			low_run(n);
			chk(32'(n), 32'(cyc[i]));
			repeat (100) @(posedge mclk_i);
		end
		bus(1'b1, STAT_OFS, 32'h40);
		done("baud");
		bus(1'b1, CTRL_OFS, 32'h3);
		bus(1'b1, BAUD_OFS, 32'h3);
		u_peer.send(8'h5A, 63, 1'b1);
		rchk(STAT_OFS, 32'h90, 32'h80);
		rchk(DATA_OFS, 32'hFF, 32'h5A);
		rchk(STAT_OFS, 32'h80, 32'h00);
		u_peer.send(8'hC3, 65, 1'b1);
		rchk(DATA_OFS, 32'hFF, 32'hC3);
		u_peer.glitch(8);
		repeat (800) @(posedge mclk_i);
		rchk(STAT_OFS, 32'h80, 32'h00);
		done("receive");
		bus(1'b1, CTRL_OFS, 32'h7);
		u_peer.send(8'hA5, 32, 1'b1);
		rchk(STAT_OFS, 32'h80, 32'h80);
		bus(1'b1, CTRL_OFS, 32'h5);
		rchk(STAT_OFS, 32'h80, 32'h00);
		bus(1'b1, CTRL_OFS, 32'h7);
		u_peer.send(8'h3C, 32, 1'b1);
		rchk(DATA_OFS, 32'hFF, 32'h3C);
		bus(1'b1, CTRL_OFS, 32'h3);
		u_peer.send(8'h81, 64, 1'b0);
		rchk(STAT_OFS, 32'h90, 32'h90);
		done("double speed and framing");
		bus(1'b1, CTRL_OFS, 32'hB);
		rchk(STAT_OFS, 32'h10, 32'h00);
		u_peer.load(8'h3C);
		repeat (60) @(posedge mclk_i);
		chk(32'(u_peer.edges), 32'd0);
		bus(1'b1, DATA_OFS, 32'hA5);
		repeat (20) @(negedge mclk_i);
		chk({31'h0, sck_oe_o}, 32'h1);
		repeat (200) @(posedge mclk_i);
		chk(32'(u_peer.edges), 32'd8);
		chk({24'h0, u_peer.mosi_q}, 32'hA5);
		rchk(STAT_OFS, 32'hD0, 32'hC0);
		rchk(DATA_OFS, 32'hFF, 32'h3C);
		u_peer.load(8'h00);
		bus(1'b1, DATA_OFS, 32'h5A);
		bus(1'b1, DATA_OFS, 32'h96);
		repeat (400) @(posedge mclk_i);
		chk(32'(u_peer.edges), 32'd16);
		chk({24'h0, u_peer.mosi_q}, 32'h96);
		done("master transfer");
		final_report();
	end
endmodule

// file: verilog/baud_gen.sv
// Fractional baud generator producing one sample tick per period.
// Assumes a synchronous active-high reset and a clock enable that freezes all state.
`timescale 1ns/10ps
module baud_gen
	import usart_pkg::*;
#(
	parameter int DIV_W = 12,
	parameter int CNT_W = 20
) (
	// Clock, reset and enable.
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Settings.
	input wire logic run_i,
	input wire logic [DIV_W-1:0] divider_i,
	input wire logic [3:0] scale_i,
	// Sample tick.
	output logic tick_o
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] frac_q;
	logic [CNT_W-1:0] reload_d;
	logic [CNT_W-1:0] frac_d;
	logic [CNT_W-1:0] sum;
	logic [CNT_W-1:0] mask;
	logic [3:0] shamt;

	// Works out the next period; a negative exponent spreads divider/2^n extra cycles.
	always_comb begin
		shamt = scale_i[3] ? (~scale_i + 4'h1) : scale_i;
		sum = frac_q + CNT_W'(divider_i);
		mask = (CNT_W'(1) << shamt) - CNT_W'(1);
		if (scale_i[3]) begin
			reload_d = sum >> shamt;
			frac_d = sum & mask;
		end else begin
			reload_d = ((CNT_W'(divider_i) + CNT_W'(1)) << shamt) - CNT_W'(1);
			frac_d = '0;
		end
	end

	// A tick is issued each time the down counter reaches zero.
	assign tick_o = run_i & ce_i & (cnt_q == '0);

	// Counts down and reloads; the remainder carries into the next period.
	always_ff @(posedge mclk_i) begin
		if (rst_i || !run_i) begin
			cnt_q <= '0;
			frac_q <= '0;
		end else if (ce_i) begin
			if (cnt_q == '0) begin
				cnt_q <= reload_d;
				frac_q <= frac_d;
			end else begin
				cnt_q <= cnt_q - CNT_W'(1);
			end
		end
	end

endmodule

// file: verilog/usart_core.sv
// Serial port core: register slave, asynchronous receive sampling, transmitter and
// master synchronous-serial transfers. Expects one AHB-Lite master with single word
// transfers, a receive line synchronous to mclk_i and a single clock domain.
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps

module usart_core
	import usart_pkg::*;
(
	// Clock, reset and enable.
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// AHB-Lite slave.
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Serial pins.
	input wire logic rxd_i,
	output logic txd_o,
	output logic txd_oe_o,
	output logic transfer_clock_pin_o,
	output logic transfer_clock_pin_oe_o
);

	ctrl_s ctrl_q;
	baud_s baud_q;
	logic wr_q;
	logic rd_q;
	logic [7:0] ofs_q;
	logic wr_data;
	logic rd_data;
	logic wr_stat;
	logic [7:0] txb_q;
	logic dre_q;
	logic txc_q;
	logic [7:0] rxb_q;
	logic rxc_q;
	logic framing_error_flag_q;
	logic tick;
	logic run;
	logic [4:0] samples;
	logic [4:0] vote_first;
	logic [4:0] vote_mid;
	tx_state_e tx_state_q;
	logic [9:0] tx_sh_q;
	logic [4:0] tx_cnt_q;
	logic [3:0] tx_bit_q;
	logic tx_done;
	logic tx_load;
	logic tx_active;
	logic xck_q;
	logic [7:0] spi_rx_q;
	rx_state_e rx_state_q;
	logic [4:0] samp_no_q;
	logic [4:0] samp_nxt;
	logic [3:0] rx_bit_q;
	logic [1:0] votes_q;
	logic vote;
	logic rx_prev_q;
	logic [7:0] rx_sh_q;
	logic rx_tick;
	logic decide;
	logic rx_frame_done;
	logic spi_rx_done;
	logic [7:0] stat_rd;

	// Two of three samples decide a level.
	function automatic logic majority(input logic a, input logic b, input logic c);
		majority = (a & b) | (a & c) | (b & c);
	endfunction

	// Bus decode: the address phase is latched, the data phase acts.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			ofs_q <= 8'h00;
		end else if (ce_i && hready_i) begin
			wr_q <= hsel_i & htrans_i[1] & hwrite_i;
			rd_q <= hsel_i & htrans_i[1] & ~hwrite_i;
			ofs_q <= haddr_i[7:0];
		end
	end

	// Zero wait states, always OKAY; hsize is accepted as a whole word.
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign wr_data = ce_i & wr_q & (ofs_q == DATA_OFS);
	assign rd_data = ce_i & rd_q & (ofs_q == DATA_OFS);
	assign wr_stat = ce_i & wr_q & (ofs_q == STAT_OFS);

	// Error flags are hidden while in master mode.
	assign stat_rd = {rxc_q, txc_q, dre_q, framing_error_flag_q & ~ctrl_q.spi_mode, 4'h0};

	// Read data mux; unmapped offsets read as zero.
	always_comb begin
		hrdata_o = 32'h0000_0000;
		if (rd_q) begin
			case (ofs_q)
				CTRL_OFS: hrdata_o = {28'h0000000, ctrl_q};
				BAUD_OFS: hrdata_o = {16'h0000, baud_q};
				DATA_OFS: hrdata_o = {24'h000000, rxb_q};
				STAT_OFS: hrdata_o = {24'h000000, stat_rd};
				default: hrdata_o = 32'h0000_0000;
			endcase
		end
	end

	// Control and baud settings.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RST;
			baud_q <= BAUD_RST;
		end else if (ce_i && wr_q) begin
			if (ofs_q == CTRL_OFS) begin
				ctrl_q <= hwdata_i[3:0];
			end
			if (ofs_q == BAUD_OFS) begin
				baud_q <= hwdata_i[15:0];
			end
		end
	end

	// Sampling geometry follows the speed select.
	assign samples = ctrl_q.double_speed_select ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
	assign vote_first = ctrl_q.double_speed_select ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
	assign vote_mid = ctrl_q.double_speed_select ? VOTE_MID_DOUBLE : VOTE_MID_NORMAL;

	// The generator runs while either direction has work.
	assign tx_active = ctrl_q.tx_en | (tx_state_q != TX_IDLE) | ~dre_q;
	assign run = tx_active | ctrl_q.rx_en;

	baud_gen #(
		.DIV_W(12),
		.CNT_W(20)
	) u_baud (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.run_i(run),
		.divider_i(baud_q.baud_divider_value),
		.scale_i(baud_q.baud_scale_exponent),
		.tick_o(tick)
	);

	// Transmit buffer: a write is taken only while empty and the transmitter is on.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			txb_q <= DATA_RST;
			dre_q <= 1'b1;
		end else if (ce_i) begin
			if (wr_data && dre_q && ctrl_q.tx_en) begin
				txb_q <= hwdata_i[7:0];
				dre_q <= 1'b0;
			end else if (tx_load) begin
				dre_q <= 1'b1;
			end
		end
	end

	// The shifter takes the buffer as soon as it is free or just finished.
	assign tx_load = ~dre_q & ((tx_state_q == TX_IDLE) | tx_done);

	// End of frame: last stop bit in async, last falling clock edge in master mode.
	always_comb begin
		tx_done = 1'b0;
		if (tick) begin
			case (tx_state_q)
				TX_ASYNC: tx_done = (tx_cnt_q == samples - 5'h01) && (tx_bit_q == LAST_ASYNC_BIT);
				TX_SPI: tx_done = xck_q && (tx_bit_q == LAST_DATA_BIT);
				default: tx_done = 1'b0;
			endcase
		end
	end

	// Transmit shifter; master mode toggles the transfer clock once per tick.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			tx_state_q <= TX_IDLE;
			tx_sh_q <= 10'h3FF;
			tx_cnt_q <= 5'h00;
			tx_bit_q <= 4'h0;
			xck_q <= 1'b0;
			spi_rx_q <= DATA_RST;
		end else if (ce_i) begin
			if (tx_load) begin
				tx_cnt_q <= 5'h00;
				tx_bit_q <= 4'h0;
				xck_q <= 1'b0;
				if (ctrl_q.spi_mode) begin
					tx_state_q <= TX_SPI;
					tx_sh_q <= {2'b11, txb_q};
				end else begin
					tx_state_q <= TX_ASYNC;
					tx_sh_q <= {1'b1, txb_q, 1'b0};
				end
			end else if (tx_done) begin
				tx_state_q <= TX_IDLE;
				xck_q <= 1'b0;
			end else if (tick) begin
				case (tx_state_q)
					TX_ASYNC: begin
						if (tx_cnt_q == samples - 5'h01) begin
							tx_cnt_q <= 5'h00;
							tx_bit_q <= tx_bit_q + 4'h1;
							tx_sh_q <= {1'b1, tx_sh_q[9:1]};
						end else begin
							tx_cnt_q <= tx_cnt_q + 5'h01;
						end
					end
					TX_SPI: begin
						xck_q <= ~xck_q;
						if (!xck_q) begin
							spi_rx_q <= {spi_rx_q[6:0], rxd_i};
						end else begin
							tx_bit_q <= tx_bit_q + 4'h1;
							tx_sh_q <= {tx_sh_q[8:0], 1'b1};
						end
					end
					default: tx_state_q <= TX_IDLE;
				endcase
			end
		end
	end

	// Transmit complete: set when the frame ends with nothing buffered; write one clears.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			txc_q <= 1'b0;
		end else if (ce_i) begin
			if (tx_done && dre_q) begin
				txc_q <= 1'b1;
			end else if (wr_stat && hwdata_i[STAT_TXC_BIT]) begin
				txc_q <= 1'b0;
			end
		end
	end

	// Pins: idle high on the data line, clock driven only in master mode.
	assign txd_o = (tx_state_q == TX_SPI) ? tx_sh_q[7] : tx_sh_q[0];
	assign txd_oe_o = tx_active;
	assign transfer_clock_pin_o = xck_q;
	assign transfer_clock_pin_oe_o = ctrl_q.spi_mode & tx_active;

	// Receive sample sequencing for asynchronous mode.
	assign rx_tick = tick & ctrl_q.rx_en & ~ctrl_q.spi_mode;
	assign samp_nxt = (samp_no_q == samples) ? 5'h01 : samp_no_q + 5'h01;
	assign decide = rx_tick & (rx_state_q != RX_IDLE) & (samp_nxt == vote_first + 5'h02);
	assign vote = majority(votes_q[1], votes_q[0], rxd_i);
	assign rx_frame_done = decide & (rx_state_q == RX_STOP);
	assign spi_rx_done = tx_done & (tx_state_q == TX_SPI) & ctrl_q.rx_en;

	// Receive state machine: start check, data bits, first stop bit.
	always_ff @(posedge mclk_i) begin
		if (rst_i || !ctrl_q.rx_en) begin
			rx_state_q <= RX_IDLE;
			samp_no_q <= 5'h00;
			rx_bit_q <= 4'h0;
			votes_q <= 2'b11;
			rx_prev_q <= 1'b1;
			rx_sh_q <= DATA_RST;
		end else if (rx_tick) begin
			case (rx_state_q)
				RX_IDLE: begin
					rx_prev_q <= rxd_i;
					if (rx_prev_q && !rxd_i) begin
						rx_state_q <= RX_START;
						samp_no_q <= 5'h01;
					end
				end
				RX_START, RX_DATA, RX_STOP: begin
					samp_no_q <= samp_nxt;
					if (samp_nxt >= vote_first && samp_nxt < vote_first + 5'h02) begin
						votes_q <= {votes_q[0], rxd_i};
					end
					if (decide) begin
						case (rx_state_q)
							RX_START: begin
								rx_bit_q <= 4'h0;
								rx_prev_q <= rxd_i;
								rx_state_q <= vote ? RX_IDLE : RX_DATA;
							end
							RX_DATA: begin
								rx_sh_q <= {vote, rx_sh_q[7:1]};
								rx_bit_q <= rx_bit_q + 4'h1;
								if (rx_bit_q == LAST_DATA_BIT) begin
									rx_state_q <= RX_STOP;
								end
							end
							default: begin
								rx_prev_q <= rxd_i;
								rx_state_q <= RX_IDLE;
							end
						endcase
					end
				end
				default: rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// Receive buffer: new data wins over a read or clear in the same cycle.
	always_ff @(posedge mclk_i) begin
		if (rst_i || !ctrl_q.rx_en) begin
			rxb_q <= DATA_RST;
			rxc_q <= 1'b0;
			framing_error_flag_q <= 1'b0;
		end else if (ce_i) begin
			if (rx_frame_done) begin
				rxb_q <= rx_sh_q;
				rxc_q <= 1'b1;
				framing_error_flag_q <= ~vote;
			end else if (spi_rx_done) begin
				rxb_q <= spi_rx_q;
				rxc_q <= 1'b1;
				framing_error_flag_q <= 1'b0;
			end else if (rd_data || (wr_stat && hwdata_i[STAT_RXC_BIT])) begin
				rxc_q <= 1'b0;
			end
		end
	end

	// Checks on the behaviour above.
	start_reject_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(decide && rx_state_q == RX_START && vote) |=> rx_state_q == RX_IDLE)
		else $error("noise start bit was not rejected");

	frame_error_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		rx_frame_done |=> (framing_error_flag_q == !$past(vote) && rxc_q))
		else $error("framing flag does not follow stop bit vote");

	spi_err_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(rd_q && ofs_q == STAT_OFS && ctrl_q.spi_mode)
			|-> hrdata_o[STAT_FRAMING_ERROR_FLAG_BIT] == 1'b0)
		else $error("error flag visible in master mode");

	load_prompt_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && !dre_q && tx_state_q == TX_IDLE) |=> (dre_q && tx_state_q != TX_IDLE))
		else $error("buffered byte not moved into shifter");

	no_self_start_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(tx_state_q == TX_IDLE && dre_q && !wr_data) |=> tx_state_q == TX_IDLE)
		else $error("transfer began without a data write");

	clock_drive_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(tx_state_q == TX_SPI) |-> (transfer_clock_pin_oe_o || !ctrl_q.spi_mode))
		else $error("transfer clock not driven during master transfer");

	sample_range_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(tx_state_q == TX_ASYNC) |-> tx_cnt_q < samples)
		else $error("bit sample count exceeds samples per bit");

	vote_mid_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		decide |-> (samp_no_q == vote_mid && samp_nxt == vote_mid + 5'h01))
		else $error("vote not centred on middle sample");

	fastest_tick_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && run && baud_q == 16'h0000 && $past(tick)
			&& $past(baud_q) == 16'h0000) |-> tick)
		else $error("divider zero must tick every cycle");

	frac_half_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(tick && $past(tick) && baud_q == 16'hF001 && $past(baud_q) == 16'hF001)
			|=> !tick)
		else $error("half-cycle fractional period not produced");

endmodule

// file: verilog/usart_pkg.sv
// Shared constants and types for the serial port baud, sampling and master-transfer block.
// Assumes a 32-bit AHB-Lite register bus and a single 125 MHz peripheral clock.
package usart_pkg;

	// Register byte offsets on the bus.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] BAUD_OFS = 8'h04;
	localparam logic [7:0] DATA_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0C;

	// Field positions.
	localparam int unsigned STAT_RXC_BIT = 7;
	localparam int unsigned STAT_TXC_BIT = 6;
	localparam int unsigned STAT_DRE_BIT = 5;
	localparam int unsigned STAT_FRAMING_ERROR_FLAG_BIT = 4;
	localparam int unsigned BAUD_SCALE_LSB = 12;

	// Values after reset.
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [15:0] BAUD_RST = 16'h0000;
	localparam logic [7:0] DATA_RST = 8'h00;

	// Oversampling and vote window, normal and double speed.
	localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
	localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
	localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
	localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
	localparam logic [4:0] VOTE_MID_NORMAL = 5'h09;
	localparam logic [4:0] VOTE_MID_DOUBLE = 5'h05;

	// Frame layout counts.
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] LAST_ASYNC_BIT = 4'h9;

	// Control register fields.
	typedef struct packed {
		logic spi_mode;
		logic double_speed_select;
		logic rx_en;
		logic tx_en;
	} ctrl_s;

	// Baud register fields.
	typedef struct packed {
		logic [3:0] baud_scale_exponent;
		logic [11:0] baud_divider_value;
	} baud_s;

	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} rx_state_e;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_ASYNC = 3'b010,
		TX_SPI = 3'b100
	} tx_state_e;

endpackage
